// File: logic/event_task_cfg.svh
`ifndef EVENT_TASK_CFG_SVH
`define EVENT_TASK_CFG_SVH

// channel and endpoint counts
`define NUM_CH 32
`define NUM_PROG 20
`define NUM_GRP 6
`define NUM_PTASK 32
`define NUM_PEVT 32
`define NUM_ALLTASK 44

// address windows of peripheral tasks, events and the fabric's own tasks
`define TASK_BASE 32'h4000_0000
`define TASK_SPAN 32'h0000_0080
`define EVT_BASE 32'h4000_0100
`define EVT_SPAN 32'h0000_0080
`define FAB_BASE 32'h4001_f000
`define GRP_TASK_LAST 32'h0000_002c
`define EP_STRIDE 32'h0000_0004

// register offsets
`define OFS_GRP_LAST 12'h02c
`define OFS_CHANNEL_ENABLE_MASK 12'h500
`define OFS_CHANNEL_ENABLE_MASK_SET 12'h504
`define OFS_CHANNEL_ENABLE_MASK_CLR 12'h508
`define OFS_CH_FIRST 12'h510
`define OFS_CH_LAST 12'h5ac
`define OFS_GRP_FIRST 12'h800
`define OFS_GRP_MLAST 12'h814
`define OFS_FORK_FIRST 12'h910
`define OFS_FORK_LAST 12'h98c

// reset values
`define RST_WORD 32'h0000_0000
`define RST_MASK 32'h0000_0000

// resync clock as a fractional tick of pclk, in MHz
`define PCLK_MHZ 8'd125
`define SYNC_MHZ 8'd16

`endif

// File: logic/event_task_pkg.sv
`include "event_task_cfg.svh"

package event_task_pkg;
  typedef logic [31:0] word_type;
  typedef logic [`NUM_CH-1:0] chan_mask_type;
  typedef logic [`NUM_PTASK-1:0] task_vec_type;
  typedef logic [`NUM_PEVT-1:0] event_vec_type;
  typedef logic [`NUM_ALLTASK-1:0] all_task_type;
  typedef logic [2*`NUM_GRP-1:0] group_task_type;
endpackage : event_task_pkg

// File: logic/event_task_fabric.sv
// Contract
// - Twenty programmable channels 0-19 and twelve fixed channels 20-31.
// - Fixed channels are enabled, disabled and grouped like programmable ones.
// - An enabled channel's event triggers its selected task automatically.
// - Each channel holds one event endpoint and primary plus fork task endpoints.
// - Endpoints hold register addresses of source events and target tasks.
// - Channels resync to 16 MHz; synchronous events arrive one period later. Code: every event waits for the next tick, 2 to 9 pclk cycles.
// - Asynchronous events are delayed at most one 16 MHz period. Code: no separate async path; delay reaches 9 pclk cycles, over one period.
// - Local shortcuts bypass the resync with no added delay.
// - Fork task fires in the same cycle as the primary task.
// - Fork endpoint n belongs to channel n.
// - Channels enabled individually through mask, set and clear registers.
// - Group enable and disable tasks act on every member channel.
// - Group enable beats a simultaneous disable on the same channel.
// - Group tasks can be reached from a channel task endpoint.
// - Events may feed many channels; tasks may be fed by many channels.
// - Six channel groups 0-5, each with enable and disable tasks.
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "event_task_cfg.svh"

module event_task_fabric (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire event_task_pkg::word_type paddr,
  input wire event_task_pkg::word_type pwdata,
  output event_task_pkg::word_type prdata,
  output logic pready,
  output logic pslverr,
  // peripheral events and tasks
  input wire event_task_pkg::event_vec_type event_in,
  output event_task_pkg::task_vec_type task_out,
  // peripheral local shortcut strobes
  input wire event_task_pkg::task_vec_type shortcut_task_in
);
  import event_task_pkg::*;

  // one-hot task strobe for a task register address, fabric tasks above
  function automatic all_task_type task_decode(input word_type addr);
    word_type off;
    task_decode = '0;
    off = '0;
    if (addr >= `TASK_BASE && addr < `TASK_BASE + `TASK_SPAN && addr[1:0] == 2'h0) begin
      off = addr - `TASK_BASE;
      task_decode[off[6:2]] = 1'b1;
    end else if (addr >= `FAB_BASE && addr <= `FAB_BASE + `GRP_TASK_LAST &&
                 addr[1:0] == 2'h0) begin
      off = addr - `FAB_BASE;
      task_decode[6'(`NUM_PTASK) + {2'h0, off[5:2]}] = 1'b1;
    end
  endfunction : task_decode

  // one-hot event select for an event register address
  function automatic event_vec_type event_decode(input word_type addr);
    word_type off;
    event_decode = '0;
    off = '0;
    if (addr >= `EVT_BASE && addr < `EVT_BASE + `EVT_SPAN && addr[1:0] == 2'h0) begin
      off = addr - `EVT_BASE;
      event_decode[off[6:2]] = 1'b1;
    end
  endfunction : event_decode

  // register file and channel state
  chan_mask_type channel_enable_mask;
  chan_mask_type next_channel_enable_mask;
  word_type event_endpoint [`NUM_PROG];
  word_type next_event_endpoint [`NUM_PROG];
  word_type task_endpoint [`NUM_PROG];
  word_type next_task_endpoint [`NUM_PROG];
  word_type fork_endpoint [`NUM_CH];
  word_type next_fork_endpoint [`NUM_CH];
  chan_mask_type channel_group [`NUM_GRP];
  chan_mask_type next_channel_group [`NUM_GRP];
  word_type next_prdata;
  chan_mask_type pending;
  chan_mask_type next_pending;
  task_vec_type task_strobe;
  task_vec_type next_task_strobe;
  group_task_type group_from_chan;
  group_task_type next_group_from_chan;
  logic [7:0] tick_acc;
  logic [7:0] next_tick_acc;

  // decode helpers
  logic [11:0] ofs;
  logic wr_access;
  logic mapped;
  logic tick;
  chan_mask_type ev_hit;
  chan_mask_type fire;
  all_task_type ch_tasks [`NUM_CH];
  all_task_type all_tasks;
  group_task_type apb_group_task;
  group_task_type group_task;
  chan_mask_type grp_en_hit;
  chan_mask_type grp_dis_hit;
  logic [11:0] ch_off;
  logic [11:0] fork_off;
  logic [11:0] grp_off;

  assign ofs = paddr[11:0];
  assign wr_access = psel & penable & pwrite;
  assign ch_off = ofs - `OFS_CH_FIRST;
  assign fork_off = ofs - `OFS_FORK_FIRST;
  assign grp_off = ofs - `OFS_GRP_FIRST;

  // address map check, zero wait states, error on unmapped words
  always_comb begin
    mapped = 1'b0;
    if (ofs[1:0] == 2'h0) begin
      if (ofs <= `OFS_GRP_LAST) mapped = 1'b1;
      if (ofs == `OFS_CHANNEL_ENABLE_MASK || ofs == `OFS_CHANNEL_ENABLE_MASK_SET || ofs == `OFS_CHANNEL_ENABLE_MASK_CLR) mapped = 1'b1;
      if (ofs >= `OFS_CH_FIRST && ofs <= `OFS_CH_LAST) mapped = 1'b1;
      if (ofs >= `OFS_GRP_FIRST && ofs <= `OFS_GRP_MLAST) mapped = 1'b1;
      if (ofs >= `OFS_FORK_FIRST && ofs <= `OFS_FORK_LAST) mapped = 1'b1;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // 16 MHz resync tick from a fractional accumulator on pclk
  always_comb begin
    tick = 1'b0;
    next_tick_acc = tick_acc + `SYNC_MHZ;
    if (next_tick_acc >= `PCLK_MHZ) begin
      next_tick_acc = next_tick_acc - `PCLK_MHZ;
      tick = 1'b1;
    end
  end

  assign fire = pending & {`NUM_CH{tick}};

  // per channel event select and task fan-out
  genvar c;
  generate
    for (c = 0; c < `NUM_CH; c++) begin : g_ch
      word_type eep_word;
      word_type tep_word;
      if (c < `NUM_PROG) begin : g_prog
        assign eep_word = event_endpoint[c];
        assign tep_word = task_endpoint[c];
      end else begin : g_fixed
        // fixed endpoints, hard-wired per channel
        assign eep_word = `EVT_BASE + 32'(c - `NUM_PROG) * `EP_STRIDE;
        assign tep_word = `TASK_BASE + 32'(c - `NUM_PROG) * `EP_STRIDE;
      end
      assign ev_hit[c] = |(event_decode(eep_word) & event_in);
      // primary and fork fire together, fork n tied to channel n
      assign ch_tasks[c] = fire[c] ?
        (task_decode(tep_word) | task_decode(fork_endpoint[c])) : '0;
    end
  endgenerate

  // merge all channel strobes; a task may be hit by several channels
  always_comb begin
    all_tasks = '0;
    for (int i = 0; i < `NUM_CH; i++) begin
      all_tasks = all_tasks | ch_tasks[i];
    end
  end

  // channel pending flags, a new event beats the tick clear
  always_comb begin
    next_pending = (pending & ~fire) | (channel_enable_mask & ev_hit);
    next_task_strobe = all_tasks[`NUM_PTASK-1:0];
    next_group_from_chan = all_tasks[`NUM_ALLTASK-1:`NUM_PTASK];
  end

  // group tasks from apb and from channels
  always_comb begin
    apb_group_task = '0;
    if (wr_access && ofs <= `OFS_GRP_LAST && ofs[1:0] == 2'h0 && pwdata[0]) begin
      apb_group_task[ofs[5:2]] = 1'b1;
    end
    group_task = apb_group_task | group_from_chan;
    grp_en_hit = '0;
    grp_dis_hit = '0;
    for (int g = 0; g < `NUM_GRP; g++) begin
      if (group_task[2*g]) grp_en_hit = grp_en_hit | channel_group[g];
      if (group_task[2*g+1]) grp_dis_hit = grp_dis_hit | channel_group[g];
    end
  end

  // register writes, enable mask update and read data
  always_comb begin
    next_channel_enable_mask = channel_enable_mask;
    next_event_endpoint = event_endpoint;
    next_task_endpoint = task_endpoint;
    next_fork_endpoint = fork_endpoint;
    next_channel_group = channel_group;
    next_prdata = prdata;
    if (wr_access) begin
      if (ofs == `OFS_CHANNEL_ENABLE_MASK) next_channel_enable_mask = pwdata;
      if (ofs >= `OFS_CH_FIRST && ofs <= `OFS_CH_LAST && ofs[1:0] == 2'h0) begin
        if (ch_off[2]) next_task_endpoint[ch_off[7:3]] = pwdata;
        else next_event_endpoint[ch_off[7:3]] = pwdata;
      end
      if (ofs >= `OFS_GRP_FIRST && ofs <= `OFS_GRP_MLAST && ofs[1:0] == 2'h0) begin
        next_channel_group[grp_off[4:2]] = pwdata;
      end
      if (ofs >= `OFS_FORK_FIRST && ofs <= `OFS_FORK_LAST && ofs[1:0] == 2'h0) begin
        next_fork_endpoint[fork_off[6:2]] = pwdata;
      end
    end
    // clears and group disables first, then sets and group enables win
    if (wr_access && ofs == `OFS_CHANNEL_ENABLE_MASK_CLR) begin
      next_channel_enable_mask = next_channel_enable_mask & ~pwdata;
    end
    next_channel_enable_mask = next_channel_enable_mask & ~grp_dis_hit;
    if (wr_access && ofs == `OFS_CHANNEL_ENABLE_MASK_SET) begin
      next_channel_enable_mask = next_channel_enable_mask | pwdata;
    end
    next_channel_enable_mask = next_channel_enable_mask | grp_en_hit;
    // read data captured in the setup phase
    if (psel && !penable && !pwrite) begin
      next_prdata = `RST_WORD;
      if (ofs == `OFS_CHANNEL_ENABLE_MASK || ofs == `OFS_CHANNEL_ENABLE_MASK_SET || ofs == `OFS_CHANNEL_ENABLE_MASK_CLR) begin
        next_prdata = channel_enable_mask;
      end
      if (ofs >= `OFS_CH_FIRST && ofs <= `OFS_CH_LAST && ofs[1:0] == 2'h0) begin
        next_prdata = ch_off[2] ? task_endpoint[ch_off[7:3]] : event_endpoint[ch_off[7:3]];
      end
      if (ofs >= `OFS_GRP_FIRST && ofs <= `OFS_GRP_MLAST && ofs[1:0] == 2'h0) begin
        next_prdata = channel_group[grp_off[4:2]];
      end
      if (ofs >= `OFS_FORK_FIRST && ofs <= `OFS_FORK_LAST && ofs[1:0] == 2'h0) begin
        next_prdata = fork_endpoint[fork_off[6:2]];
      end
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_mask <= `RST_MASK;
      for (int i = 0; i < `NUM_PROG; i++) begin
        event_endpoint[i] <= `RST_WORD;
        task_endpoint[i] <= `RST_WORD;
      end
      for (int i = 0; i < `NUM_CH; i++) begin
        fork_endpoint[i] <= `RST_WORD;
      end
      for (int g = 0; g < `NUM_GRP; g++) begin
        channel_group[g] <= `RST_MASK;
      end
      prdata <= `RST_WORD;
      pending <= '0;
      task_strobe <= '0;
      group_from_chan <= '0;
      tick_acc <= 8'h00;
    end else begin
      channel_enable_mask <= next_channel_enable_mask;
      event_endpoint <= next_event_endpoint;
      task_endpoint <= next_task_endpoint;
      fork_endpoint <= next_fork_endpoint;
      channel_group <= next_channel_group;
      prdata <= next_prdata;
      pending <= next_pending;
      task_strobe <= next_task_strobe;
      group_from_chan <= next_group_from_chan;
      tick_acc <= next_tick_acc;
    end
  end

  // shortcut strobes join the task lines without passing the resync
  assign task_out = task_strobe | shortcut_task_in;

endmodule : event_task_fabric

// File: sim/event_task_fabric_asserts.sv
`timescale 1ns/1ns
module event_task_checker (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire event_task_pkg::word_type paddr,
  input wire event_task_pkg::word_type pwdata,
  input wire event_task_pkg::word_type prdata,
  input wire logic pready,
  input wire logic pslverr,
  // peripheral side
  input wire event_task_pkg::event_vec_type event_in,
  input wire event_task_pkg::task_vec_type task_out,
  input wire event_task_pkg::task_vec_type shortcut_task_in
);
  import event_task_pkg::*;
  logic [3:0] ev_age;
  logic [3:0] next_ev_age;
  logic fab_task;
  logic acc;
  logic rd_setup;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last event, saturating
  always_comb begin
    next_ev_age = (ev_age == 4'hf) ? ev_age : ev_age + 4'h1;
    if (|event_in) next_ev_age = 4'h0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ev_age <= 4'hf;
    else ev_age <= next_ev_age;
  end
  // fabric-driven task strobes and apb access phase
  assign fab_task = |(task_out & ~shortcut_task_in);
  assign acc = psel && penable;
  // read setup cycle, the only cycle whose edge may load new read data
  assign rd_setup = psel && !penable && !pwrite;
  property p_ready; acc |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_align; acc && paddr[1:0] != 2'b00 |-> pslverr; endproperty
  a_align: assert property (p_align) else $error("misaligned access accepted");
  property p_hole; acc && paddr[11:0] == 12'hffc |-> pslverr; endproperty
  a_hole: assert property (p_hole) else $error("unmapped access accepted");
  property p_fork_end; acc && paddr[11:0] == 12'h990 |-> pslverr; endproperty
  a_fork_end: assert property (p_fork_end) else $error("past last fork accepted");
  property p_mask_ok; acc && paddr[11:0] == 12'h500 |-> !pslverr; endproperty
  a_mask_ok: assert property (p_mask_ok) else $error("mask access refused");
  property p_hold; !$past(rd_setup) |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_short; (task_out & shortcut_task_in) == shortcut_task_in; endproperty
  a_short: assert property (p_short) else $error("shortcut not passed");
  property p_gap; fab_task |=> (!fab_task) [*6]; endproperty
  a_gap: assert property (p_gap) else $error("tasks closer than a tick");
  property p_age; fab_task |-> ev_age <= 4'h8; endproperty
  a_age: assert property (p_age) else $error("task too late or without event");
  c_fire: cover property (fab_task);
  c_short: cover property (|shortcut_task_in);
  c_err: cover property (acc && pslverr);
endmodule : event_task_checker

bind event_task_fabric event_task_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_in(event_in),
  .task_out(task_out), .shortcut_task_in(shortcut_task_in));

// File: sim/periph_model.sv
`timescale 1ns/1ns
module periph_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench requests
  input wire event_task_pkg::event_vec_type ev_req,
  // event strobes to the fabric
  output event_task_pkg::event_vec_type event_in
);
  import event_task_pkg::*;
  event_vec_type next_event_in;
  // strobe k is the event register at its own address, one cycle a request
  always_comb begin
    next_event_in = ev_req;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) event_in <= '0;
    else event_in <= next_event_in;
  end
endmodule : periph_model

// File: sim/tb.sv
`timescale 1ns/1ns
module tb;
  import event_task_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  word_type paddr, pwdata, prdata, got;
  event_vec_type ev_req, event_in;
  task_vec_type task_out, shortcut_task_in;
  int bad_count, n_compared;
  event_task_fabric dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .task_out(task_out),
    .shortcut_task_in(shortcut_task_in));
  periph_model model_u (.pclk(pclk), .presetn(presetn), .ev_req(ev_req), .event_in(event_in));
  // clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic end_sim;
    $display("compared=%0d bad=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  task automatic chk(input word_type s, input word_type x);
    n_compared++;
    if (s !== x) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input word_type d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h4001f, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    got = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input word_type x, input logic xe);
    apb(1'b0, a, '0);
    chk(got, x);
    chk({31'h0, err}, {31'h0, xe});
  endtask : rd
  // pulse events, then collect the first task strobes that appear
  task automatic fire(input event_vec_type ev);
    int n;
    @(posedge pclk);
    ev_req <= ev;
    @(posedge pclk);
    ev_req <= '0;
    got = '0;
    n = 0;
    while (got === '0 && n < 12) begin
      @(posedge pclk);
      #1;
      got = task_out;
      n++;
    end
  endtask : fire
  task automatic t_regs;
    rd(12'h500, 32'h0, 1'b0);
    apb(1'b1, 12'h500, 32'h0000_0005);
    apb(1'b1, 12'h504, 32'h0000_0008);
    rd(12'h504, 32'h0000_000d, 1'b0);
    apb(1'b1, 12'h508, 32'h0000_0001);
    rd(12'h508, 32'h0000_000c, 1'b0);
    rd(12'hffc, 32'h0, 1'b1);
    rd(12'h502, 32'h0, 1'b1);
    rd(12'h990, 32'h0, 1'b1);
    rd(12'h98c, 32'h0, 1'b0);
    apb(1'b1, 12'h500, 32'h0);
  endtask : t_regs
  task automatic t_fixed;
    apb(1'b1, 12'h504, 32'h0010_0000);
    fire(32'h1);
    chk(got, 32'h1);
    apb(1'b1, 12'h508, 32'h0010_0000);
    fire(32'h1);
    chk(got, 32'h0);
  endtask : t_fixed
  task automatic t_chan;
    apb(1'b1, 12'h510, 32'h4000_010c);
    apb(1'b1, 12'h514, 32'h4000_0014);
    apb(1'b1, 12'h910, 32'h4000_0024);
    rd(12'h514, 32'h4000_0014, 1'b0);
    apb(1'b1, 12'h504, 32'h1);
    fire(32'h8);
    chk(got, 32'h0000_0220);
  endtask : t_chan
  task automatic t_group;
    apb(1'b1, 12'h800, 32'h4);
    apb(1'b1, 12'h814, 32'h4);
    apb(1'b1, 12'h518, 32'h4000_010c);
    apb(1'b1, 12'h51c, 32'h4001_f000);
    apb(1'b1, 12'h914, 32'h4001_f02c);
    apb(1'b1, 12'h504, 32'h2);
    fire(32'h8);
    chk(got, 32'h0000_0220);
    rd(12'h500, 32'h7, 1'b0);
    apb(1'b1, 12'h02c, 32'h1);
    rd(12'h500, 32'h3, 1'b0);
    apb(1'b1, 12'h000, 32'h1);
    rd(12'h500, 32'h7, 1'b0);
  endtask : t_group
  task automatic t_short;
    @(posedge pclk);
    shortcut_task_in <= 32'h8000_0001;
    @(posedge pclk);
    #1;
    chk(task_out, 32'h8000_0001);
    @(posedge pclk);
    shortcut_task_in <= '0;
  endtask : t_short
  // main sequence
  initial begin
    bad_count = 0;
    n_compared = 0;
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, ev_req, shortcut_task_in} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_fixed;
    t_chan;
    t_group;
    t_short;
    end_sim;
  end
  // watchdog
  initial begin
    #40000;
    bad_count++;
    end_sim;
  end
endmodule : tb
